// ===== design/hbp_pkg.sv
package hbp_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_CHCTL0 = 8'h08;
    localparam logic [7:0] ADDR_CHCTL1 = 8'h0c;
    localparam logic [7:0] ADDR_DUTY0  = 8'h10;
    localparam logic [7:0] ADDR_DUTY1  = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int CNT_W           = 11;
    localparam int CTRL_SHORT_BIT  = 0;
    localparam int CTRL_FW_BIT     = 1;
    localparam int CHCTL_ALIGN_LSB = 0;
    localparam int CHCTL_MODE_LSB  = 4;
    localparam int DUTY_SIGN_BIT   = 15;
    localparam int ST_ODD_LSB      = 12;
    localparam int ST_EFF_LSB      = 16;
    localparam int ST_PEND_BIT     = 20;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] ALIGN_OFF    = 2'h0;
    localparam logic [1:0] ALIGN_LEFT   = 2'h1;
    localparam logic [1:0] ALIGN_RIGHT  = 2'h2;
    localparam logic [1:0] ALIGN_CENTER = 2'h3;
    localparam logic [1:0] MODE_HALF_N  = 2'h0;
    localparam logic [1:0] MODE_HALF_P  = 2'h1;
    localparam logic [1:0] MODE_FULL    = 2'h2;
    localparam logic [1:0] MODE_DUAL    = 2'h3;

    // Switch bit order: [0] a, [1] b, [2] c, [3] d
    localparam logic [3:0] SW_NONE   = 4'h0;
    localparam logic [3:0] SW_ALL    = 4'hf;
    localparam logic [3:0] SW_AB     = 4'h3;
    localparam logic [3:0] SW_CD     = 4'hc;
    localparam logic [3:0] SW_A      = 4'h1;
    localparam logic [3:0] SW_B      = 4'h2;
    localparam logic [3:0] SW_C      = 4'h4;
    localparam logic [3:0] SW_D      = 4'h8;
    localparam logic [3:0] SW_AD     = 4'h9;
    localparam logic [3:0] SW_BC     = 4'h6;
    localparam logic [3:0] SW_AC     = 4'h5;
    localparam logic [3:0] SW_BD     = 4'ha;

    typedef enum logic [1:0] {
        EFF_OFF  = 2'h0,
        EFF_HALF = 2'h1,
        EFF_FULL = 2'h3,
        EFF_DUAL = 2'h2
    } hbp_eff_type;

    typedef struct packed {
        logic pos_out;
        logic pos_oe;
        logic neg_out;
        logic neg_oe;
    } hbp_pin_type;

    typedef struct packed {
        logic [3:0] on;
        logic [3:0] ctl;
    } hbp_sw_type;

    typedef struct packed {
        logic                         ack;
        logic [31:0]                  rdat;
        logic                         short_mode;
        logic                         fw_sel;
        logic [CNT_W-1:0]             period;
        logic [CNT_W-1:0]             cnt;
        logic [1:0][1:0]              align;
        logic [1:0][1:0]              omode;
        logic [1:0]                   sign;
        logic [1:0][CNT_W-1:0]        duty;
        logic [1:0]                   wsign;
        logic [1:0][CNT_W-1:0]        wduty;
        logic [1:0]                   odd_period;
        logic                         dual_pend;
        hbp_sw_type [1:0]             sw;
        hbp_pin_type [1:0]            pin;
    } hbp_state_type;

    localparam hbp_state_type RST_STATE = '0;

endpackage : hbp_pkg

// ===== design/hbp_output_stage.sv
`timescale 1ns/1ps

module hbp_output_stage (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_wb_cyc,
    input  wire logic                     i_wb_stb,
    input  wire logic                     i_wb_we,
    input  wire logic [7:0]               i_wb_adr,
    input  wire logic [3:0]               i_wb_sel,
    input  wire logic [31:0]              i_wb_dat,
    output logic                          o_wb_ack,
    output logic [31:0]                   o_wb_dat,
    output hbp_pkg::hbp_pin_type [1:0]    o_pin,
    output hbp_pkg::hbp_sw_type [1:0]     o_sw
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    hbp_pkg::hbp_state_type           st;
    hbp_pkg::hbp_state_type           next_st;
    hbp_pkg::hbp_eff_type             eff [2];
    logic [1:0]                       act;
    logic [1:0]                       load;
    logic [1:0]                       en;
    logic [1:0][3:0]                  sw_on_n;
    logic [1:0][3:0]                  sw_ctl_n;
    logic                             wr;
    logic                             ovf;
    logic [7:0]                       wadr;
    logic [1:0][31:0]                 duty_rd;
    logic [31:0]                      rd_word;

    assign wadr = {i_wb_adr[7:2], 2'h0};
    // Write commits on the edge where the master sees ack
    assign wr   = i_wb_cyc && i_wb_stb && i_wb_we && st.ack;
    assign ovf  = (st.period != '0) && (st.cnt >= st.period - 11'h001);

    // ------------------------------------------------------------------
    // Per-channel mode, phase and switch decode
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_ch
        localparam int J = 1 - i;
        logic              right_phase;
        logic              left_act;
        logic              right_act;
        logic              dual_ok;

        assign en[i]       = st.align[i] != hbp_pkg::ALIGN_OFF;
        assign dual_ok     = en[0] && en[1] &&
                             st.omode[i] == hbp_pkg::MODE_DUAL &&
                             st.omode[J] == hbp_pkg::MODE_DUAL;
        assign right_phase = st.align[i] == hbp_pkg::ALIGN_RIGHT ||
                             (st.align[i] == hbp_pkg::ALIGN_CENTER &&
                              st.odd_period[i]);
        assign left_act    = st.wduty[i] > st.cnt;
        assign right_act   = ({1'b0, st.cnt} + {1'b0, st.wduty[i]}) >=
                             {1'b0, st.period};
        assign act[i]      = right_phase ? right_act : left_act;
        assign load[i]     = st.period == '0 || !en[i] ||
                             (ovf && eff[i] != hbp_pkg::EFF_DUAL) ||
                             (ovf && st.dual_pend);

        always_comb
        begin
            if (!en[i] || st.period == '0)
                eff[i] = hbp_pkg::EFF_OFF;
            else if (!st.omode[i][1])
                eff[i] = hbp_pkg::EFF_HALF;
            else if (dual_ok)
                eff[i] = hbp_pkg::EFF_DUAL;
            else
                eff[i] = hbp_pkg::EFF_FULL;
        end

        always_comb
        begin
            case (eff[i])
                hbp_pkg::EFF_HALF:
                begin
                    // Direction and freewheel play no part here
                    if (st.omode[i] == hbp_pkg::MODE_HALF_N)
                    begin
                        sw_ctl_n[i] = hbp_pkg::SW_CD;
                        sw_on_n[i]  = act[i] ? hbp_pkg::SW_D
                                             : hbp_pkg::SW_C;
                    end
                    else
                    begin
                        sw_ctl_n[i] = hbp_pkg::SW_AB;
                        sw_on_n[i]  = act[i] ? hbp_pkg::SW_B
                                             : hbp_pkg::SW_A;
                    end
                end
                hbp_pkg::EFF_FULL, hbp_pkg::EFF_DUAL:
                begin
                    sw_ctl_n[i] = hbp_pkg::SW_ALL;
                    if (act[i])
                        sw_on_n[i] = st.wsign[i] ? hbp_pkg::SW_BC
                                                 : hbp_pkg::SW_AD;
                    else
                        sw_on_n[i] = st.fw_sel ? hbp_pkg::SW_BD
                                               : hbp_pkg::SW_AC;
                end
                default:
                begin
                    sw_ctl_n[i] = hbp_pkg::SW_NONE;
                    sw_on_n[i]  = hbp_pkg::SW_NONE;
                end
            endcase
        end

        assign duty_rd[i] = st.short_mode ?
            {16'h0, st.sign[i], st.duty[i][8:2], 8'h00} :
            {16'h0, st.sign[i], 4'h0, st.duty[i]};
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        case (wadr)
            hbp_pkg::ADDR_CTRL:
                rd_word = {30'h0, st.fw_sel, st.short_mode};
            hbp_pkg::ADDR_PERIOD:
                rd_word = {21'h0, st.period};
            hbp_pkg::ADDR_CHCTL0:
                rd_word = {26'h0, st.omode[0], 2'h0, st.align[0]};
            hbp_pkg::ADDR_CHCTL1:
                rd_word = {26'h0, st.omode[1], 2'h0, st.align[1]};
            hbp_pkg::ADDR_DUTY0:
                rd_word = duty_rd[0];
            hbp_pkg::ADDR_DUTY1:
                rd_word = duty_rd[1];
            hbp_pkg::ADDR_STATUS:
                rd_word = {11'h0, st.dual_pend, eff[1], eff[0], 2'h0,
                           st.odd_period, 1'b0, st.cnt};
            default:
                rd_word = 32'h0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st     = st;
        next_st.ack = i_wb_cyc && i_wb_stb && !st.ack;
        if (next_st.ack)
            next_st.rdat = rd_word;

        if (wr && wadr == hbp_pkg::ADDR_CTRL && i_wb_sel[0])
        begin
            next_st.short_mode = i_wb_dat[hbp_pkg::CTRL_SHORT_BIT];
            next_st.fw_sel     = i_wb_dat[hbp_pkg::CTRL_FW_BIT];
        end
        if (wr && wadr == hbp_pkg::ADDR_PERIOD)
        begin
            if (i_wb_sel[0])
                next_st.period[7:0]  = i_wb_dat[7:0];
            if (i_wb_sel[1])
                next_st.period[10:8] = i_wb_dat[10:8];
        end

        // Timer counter
        if (st.period == '0 || ovf)
            next_st.cnt = '0;
        else
            next_st.cnt = st.cnt + 11'h001;

        for (int k = 0; k < 2; k++)
        begin
            if (wr && i_wb_sel[0] &&
                wadr == (k == 0 ? hbp_pkg::ADDR_CHCTL0
                                : hbp_pkg::ADDR_CHCTL1))
            begin
                next_st.align[k] = i_wb_dat[hbp_pkg::CHCTL_ALIGN_LSB +: 2];
                next_st.omode[k] = i_wb_dat[hbp_pkg::CHCTL_MODE_LSB +: 2];
            end
            if (wr && wadr == (k == 0 ? hbp_pkg::ADDR_DUTY0
                                      : hbp_pkg::ADDR_DUTY1))
            begin
                if (st.short_mode)
                begin
                    if (i_wb_sel[1])
                    begin
                        next_st.sign[k] = i_wb_dat[hbp_pkg::DUTY_SIGN_BIT];
                        next_st.duty[k] = {2'h0, i_wb_dat[14:8], 2'h0};
                    end
                end
                else
                begin
                    // Byte halves land apart; only a full word is coherent
                    if (i_wb_sel[1])
                    begin
                        next_st.sign[k]       =
                            i_wb_dat[hbp_pkg::DUTY_SIGN_BIT];
                        next_st.duty[k][10:8] = i_wb_dat[10:8];
                    end
                    if (i_wb_sel[0])
                        next_st.duty[k][7:0] = i_wb_dat[7:0];
                end
            end

            // Center alignment restarts on an even period only when off
            if (!en[k])
                next_st.odd_period[k] = 1'b0;
            else if (ovf)
                next_st.odd_period[k] = !st.odd_period[k];

            if (load[k])
            begin
                next_st.wduty[k] = st.duty[k];
                next_st.wsign[k] = st.sign[k];
            end

            next_st.sw[k].on  = sw_on_n[k];
            next_st.sw[k].ctl = sw_ctl_n[k];
            // Pos pin from a (high) / b (low), neg pin from c / d
            next_st.pin[k].pos_out = sw_on_n[k][0];
            next_st.pin[k].pos_oe  = sw_ctl_n[k][0];
            next_st.pin[k].neg_out = sw_on_n[k][2];
            next_st.pin[k].neg_oe  = sw_ctl_n[k][2];
        end

        // Set wins over the overflow clear; odd write arms the pair
        if (ovf)
            next_st.dual_pend = 1'b0;
        if (wr && wadr == hbp_pkg::ADDR_DUTY1)
            next_st.dual_pend = 1'b1;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            st <= hbp_pkg::RST_STATE;
        else
            st <= next_st;
    end

    assign o_wb_ack = st.ack;
    assign o_wb_dat = st.rdat;
    assign o_pin    = st.pin;
    assign o_sw     = st.sw;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic                             odd_wr;

    assign odd_wr = wr && wadr == hbp_pkg::ADDR_DUTY1;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_enable(int c);
        !en[c] ##1 en[c];
    endsequence

    property p_dual_needs_both(int c);
        eff[c] == hbp_pkg::EFF_DUAL |-> en[0] && en[1] &&
            st.omode[0] == hbp_pkg::MODE_DUAL &&
            st.omode[1] == hbp_pkg::MODE_DUAL;
    endproperty
    a_dual_needs_both: assert property (p_dual_needs_both(0))
        else $error("dual mode without both channels set");

    property p_lone_dual_full;
        st.omode[0] == hbp_pkg::MODE_DUAL && en[0] && st.period != '0 &&
            !(en[1] && st.omode[1] == hbp_pkg::MODE_DUAL)
            |-> eff[0] == hbp_pkg::EFF_FULL;
    endproperty
    a_lone_dual_full: assert property (p_lone_dual_full)
        else $error("lone dual request not run as full bridge");

    property p_short_write;
        wr && st.short_mode && i_wb_sel[1] && wadr == hbp_pkg::ADDR_DUTY0
        |=> st.duty[0] == {2'h0, $past(i_wb_dat[14:8]), 2'h0};
    endproperty
    a_short_write: assert property (p_short_write)
        else $error("short write did not map high byte");

    property p_dual_load;
        eff[1] == hbp_pkg::EFF_DUAL && ovf && st.dual_pend
        |=> st.wduty[1] == $past(st.duty[1]) &&
            st.dual_pend == $past(odd_wr);
    endproperty
    a_dual_load: assert property (p_dual_load)
        else $error("dual pair not loaded at overflow");

    property p_dual_hold;
        eff[0] == hbp_pkg::EFF_DUAL && ovf && !st.dual_pend
        |=> st.wduty[0] == $past(st.wduty[0]);
    endproperty
    a_dual_hold: assert property (p_dual_hold)
        else $error("dual working duty loaded before odd write");

    property p_full_load;
        eff[0] == hbp_pkg::EFF_FULL && ovf
        |=> st.wduty[0] == $past(st.duty[0]);
    endproperty
    a_full_load: assert property (p_full_load)
        else $error("full bridge duty not reloaded at overflow");

    property p_off_released;
        eff[1] == hbp_pkg::EFF_OFF |=> o_sw[1].ctl == hbp_pkg::SW_NONE &&
            !o_pin[1].pos_oe && !o_pin[1].neg_oe;
    endproperty
    a_off_released: assert property (p_off_released)
        else $error("switches controlled while channel off");

    property p_left_start;
        st.align[0] == hbp_pkg::ALIGN_LEFT && st.cnt == '0 &&
            st.wduty[0] != '0 |-> act[0];
    endproperty
    a_left_start: assert property (p_left_start)
        else $error("left aligned period not starting active");

    property p_right_start;
        st.align[0] == hbp_pkg::ALIGN_RIGHT && st.cnt == '0 &&
            st.wduty[0] < st.period |-> !act[0];
    endproperty
    a_right_start: assert property (p_right_start)
        else $error("right aligned period not starting inactive");

    property p_center_even;
        s_enable(0) |-> !st.odd_period[0];
    endproperty
    a_center_even: assert property (p_center_even)
        else $error("enable did not start on even period");

    property p_full_pattern;
        eff[0] == hbp_pkg::EFF_FULL && !st.fw_sel && act[0] &&
            !st.wsign[0] ##1 1'b1 |-> o_sw[0].on == hbp_pkg::SW_AD &&
            o_pin[0].pos_out && !o_pin[0].neg_out;
    endproperty
    a_full_pattern: assert property (p_full_pattern)
        else $error("full bridge active pattern wrong");

    property p_fw_passive;
        eff[1] == hbp_pkg::EFF_FULL && st.fw_sel && !act[1]
        |=> o_sw[1].on == hbp_pkg::SW_BD && !o_pin[1].pos_out;
    endproperty
    a_fw_passive: assert property (p_fw_passive)
        else $error("freewheel low side passive pattern wrong");

    property p_half_neg;
        eff[0] == hbp_pkg::EFF_HALF && st.omode[0] == hbp_pkg::MODE_HALF_N
        |=> o_sw[0].ctl == hbp_pkg::SW_CD && !o_pin[0].pos_oe;
    endproperty
    a_half_neg: assert property (p_half_neg)
        else $error("half bridge released wrong pin");

endmodule : hbp_output_stage

// ===== verif/hbp_coil_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Coil driver stage on the far side of the pins
// ------------------------------------------------------------------
module hbp_coil_model (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst,
    input  wire hbp_pkg::hbp_pin_type [1:0] i_pin,
    input  wire hbp_pkg::hbp_sw_type [1:0]  i_sw,
    output logic [3:0]                      o_level,
    output logic                            o_short_seen
);
    logic [3:0] last;

    // Released pins wander, so stale levels never pass for driven ones
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            o_level[2*i]   = i_pin[i].pos_oe ? i_pin[i].pos_out : ~last[2*i];
            o_level[2*i+1] = i_pin[i].neg_oe ? i_pin[i].neg_out
                                             : ~last[2*i+1];
        end
    end

    // Both switches of one leg closed would short the coil supply
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            last         <= 4'h0;
            o_short_seen <= 1'b0;
        end
        else
        begin
            last <= o_level;
            for (int i = 0; i < 2; i++)
            begin
                if ((i_sw[i].on[0] & i_sw[i].on[1]) |
                    (i_sw[i].on[2] & i_sw[i].on[3]))
                    o_short_seen <= 1'b1;
            end
        end
    end
endmodule : hbp_coil_model

// ===== verif/hbp_output_stage_test.sv
`timescale 1ns/1ps

module hbp_output_stage_test;
    logic                       clk;
    logic                       rst;
    logic                       cyc;
    logic                       we;
    logic [7:0]                 adr;
    logic [3:0]                 sel;
    logic [31:0]                wdat;
    logic                       ack;
    logic [31:0]                rdat;
    hbp_pkg::hbp_pin_type [1:0] pin;
    hbp_pkg::hbp_sw_type [1:0]  sw;
    logic [3:0]                 level;
    logic                       short_seen;
    logic [31:0]                q;
    int                         bad_count;
    int                         compares;
    // Row: mode0,mode1 | fw,dir,active,0 | on | ctl | 00,eff
    logic [19:0]                rows [12] = '{
        20'h028c1, 20'h0c4c1, 20'h46231, 20'h48131, 20'h829f3, 20'h805f3,
        20'h866f3, 20'h8a9f3, 20'hacaf3, 20'hf45f2, 20'hfa9f2, 20'hee6f3};

    hbp_output_stage u_dut (
        .i_ref_clk (clk),
        .i_rst     (rst),
        .i_wb_cyc  (cyc),
        .i_wb_stb  (cyc),
        .i_wb_we   (we),
        .i_wb_adr  (adr),
        .i_wb_sel  (sel),
        .i_wb_dat  (wdat),
        .o_wb_ack  (ack),
        .o_wb_dat  (rdat),
        .o_pin     (pin),
        .o_sw      (sw)
    );

    hbp_coil_model u_coil (
        .i_ref_clk    (clk),
        .i_rst        (rst),
        .i_pin        (pin),
        .i_sw         (sw),
        .o_level      (level),
        .o_short_seen (short_seen)
    );

    always #10 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic end_sim;
        $display("bad_count=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                bad_count++;
                end_sim();
            end
            @(posedge clk);
        end
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, 4'h3, {16'h0000, d});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'h3, 32'h0);
        chk(q, exp);
    endtask : rd

    // Both channels off before the freewheel side changes
    task automatic setup(input logic [1:0] m0, input logic [1:0] m1,
                         input logic fw, input logic dir,
                         input logic [10:0] duty, input logic [1:0] al);
        wr(hbp_pkg::ADDR_CHCTL0, 16'h0000);
        wr(hbp_pkg::ADDR_CHCTL1, 16'h0000);
        wr(hbp_pkg::ADDR_CTRL, {14'h0000, fw, 1'b0});
        chk({24'h0, sw[0]}, 32'h0);
        wr(hbp_pkg::ADDR_PERIOD, 16'h0008);
        wr(hbp_pkg::ADDR_DUTY0, {dir, 4'h0, duty});
        wr(hbp_pkg::ADDR_DUTY1, {dir, 4'h0, duty});
        wr(hbp_pkg::ADDR_CHCTL1, {10'h000, m1, 2'h0, al});
        wr(hbp_pkg::ADDR_CHCTL0, {10'h000, m0, 2'h0, al});
    endtask : setup

    // Duty 3 of period 8 over 48 counts; neg pin low is active
    task automatic measure(input logic [1:0] al, input int on_exp,
                           input int run_exp);
        int hits;
        int runs;
        int best;
        hits = 0;
        runs = 0;
        best = 0;
        setup(hbp_pkg::MODE_FULL, hbp_pkg::MODE_FULL, 1'b0, 1'b0,
              11'h003, al);
        repeat (48)
        begin
            @(posedge clk);
            runs = (level[1] === 1'b0) ? runs + 1 : 0;
            hits = (level[1] === 1'b0) ? hits + 1 : hits;
            best = (runs > best) ? runs : best;
        end
        chk(32'(hits), 32'(on_exp));
        chk(32'(best), 32'(run_exp));
    endtask : measure

    task automatic do_reset;
        rst <= 1'b1;
        tick(10);
        rst <= 1'b0;
        tick(1);
        chk({8'h00, pin, sw}, 32'h0);
        rd(hbp_pkg::ADDR_PERIOD, 32'h0);
    endtask : do_reset

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clk       = 1'b0;
        rst       = 1'b1;
        cyc       = 1'b0;
        we        = 1'b0;
        adr       = 8'h00;
        sel       = 4'h0;
        wdat      = 32'h0;
        bad_count = 0;
        compares  = 0;
        do_reset();
        foreach (rows[i])
        begin
            setup(rows[i][19:18], rows[i][17:16], rows[i][15], rows[i][14],
                  rows[i][13] ? 11'h008 : 11'h000, hbp_pkg::ALIGN_LEFT);
            tick(20);
            chk({24'h0, sw[0]}, {24'h0, rows[i][11:4]});
            chk({28'h0, pin[0]}, {28'h0, rows[i][8], rows[i][4],
                rows[i][10], rows[i][6]});
            bus(1'b0, hbp_pkg::ADDR_STATUS, 4'h3, 32'h0);
            chk({30'h0, q[17:16]}, {30'h0, rows[i][1:0]});
        end
        measure(hbp_pkg::ALIGN_LEFT, 18, 3);
        measure(hbp_pkg::ALIGN_RIGHT, 18, 3);
        measure(hbp_pkg::ALIGN_CENTER, 18, 6);
        // Dual pair holds the old duty until the odd register is written
        setup(hbp_pkg::MODE_DUAL, hbp_pkg::MODE_DUAL, 1'b0, 1'b0,
              11'h000, hbp_pkg::ALIGN_LEFT);
        // Let an overflow retire the odd write made during setup
        tick(20);
        wr(hbp_pkg::ADDR_DUTY0, 16'h0004);
        wr(hbp_pkg::ADDR_DUTY0, 16'h0008);
        tick(20);
        chk({24'h0, sw[0]}, 32'h5f);
        wr(hbp_pkg::ADDR_DUTY1, 16'h0008);
        tick(20);
        chk({24'h0, sw[0]}, 32'h9f);
        setup(hbp_pkg::MODE_FULL, hbp_pkg::MODE_FULL, 1'b0, 1'b0,
              11'h000, hbp_pkg::ALIGN_LEFT);
        wr(hbp_pkg::ADDR_DUTY0, 16'h0008);
        tick(20);
        chk({24'h0, sw[0]}, 32'h9f);
        wr(hbp_pkg::ADDR_PERIOD, 16'h0000);
        tick(3);
        chk({8'h00, pin, sw}, 32'h0);
        // Short write mode keeps only the high byte
        wr(hbp_pkg::ADDR_CTRL, 16'h0001);
        bus(1'b1, hbp_pkg::ADDR_DUTY0, 4'h2, 32'h0000_0200);
        rd(hbp_pkg::ADDR_DUTY0, 32'h0000_0200);
        wr(hbp_pkg::ADDR_DUTY0, 16'h81ff);
        rd(hbp_pkg::ADDR_DUTY0, 32'h0000_8100);
        wr(hbp_pkg::ADDR_CTRL, 16'h0000);
        rd(hbp_pkg::ADDR_DUTY0, 32'h0000_8004);
        wr(hbp_pkg::ADDR_DUTY0, 16'h07ff);
        rd(hbp_pkg::ADDR_DUTY0, 32'h0000_07ff);
        wr(8'h1c, 16'hffff);
        rd(8'h1c, 32'h0);
        setup(hbp_pkg::MODE_FULL, hbp_pkg::MODE_HALF_P, 1'b0, 1'b0,
              11'h008, hbp_pkg::ALIGN_LEFT);
        tick(20);
        do_reset();
        chk({31'h0, short_seen}, 32'h0);
        end_sim();
    end
endmodule : hbp_output_stage_test
